// ===== rtl/eeprom_spi_pkg.sv
// Shared constants, opcodes and status layout for the serial front end
package eeprom_spi_pkg;

    // Opcode compare mask: bit 3 of every opcode is don't-care
    localparam logic [7:0] OPCODE_MASK     = 8'hF7;
    localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD       = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD      = 8'h01;
    localparam logic [7:0] READ_ARRAY_CMD        = 8'h03;
    localparam logic [7:0] WRITE_ARRAY_CMD       = 8'h02;

    // Status byte field positions
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_LATCH_BIT    = 1;
    localparam int ST_LEVEL_LO_BIT = 2;
    localparam int ST_LEVEL_HI_BIT = 3;
    localparam int ST_PROTECT_BIT  = 7;

    // Status byte seen while an internal write cycle runs
    localparam logic [7:0] STATUS_BUSY_VIEW = 8'hFF;
    // Status byte before the first publish
    localparam logic [7:0] STATUS_RESET_VIEW = 8'h00;

    // Nonvolatile protect fields: power-up values (plain defaults)
    localparam logic [1:0] LEVEL_RESET   = 2'h0;
    localparam logic       PROTECT_RESET = 1'b0;

    // Bit counter width and last bit index of a byte
    localparam int          BIT_CNT_W = 3;
    localparam logic [2:0]  LAST_BIT  = 3'h7;

    // Internal write cycle time
    localparam int WRITE_CYCLE_NS  = 10_000_000;
    localparam int MCLK_PERIOD_NS  = 10;
    localparam int WRITE_CYCLES    = WRITE_CYCLE_NS / MCLK_PERIOD_NS;
    localparam int WC_CNT_W        = 24;

    // Phase of the serial frame
    typedef enum logic [1:0] {
        PH_OPCODE,
        PH_STATUS_OUT,
        PH_STATUS_DATA,
        PH_IGNORE
    } phase_e;

    // Status-write sequencer on the system clock
    typedef enum logic [1:0] {
        WS_IDLE,
        WS_ARMED,
        WS_BUSY
    } wstate_e;

endpackage

// ===== rtl/sync_agree.sv
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/100ps
module sync_agree
    import eeprom_spi_pkg::*;
#(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_q;    // First stage, read only by s2_q
    logic [WIDTH-1:0] s2_q;    // Second stage
    logic [WIDTH-1:0] s3_q;    // Third stage
    logic [WIDTH-1:0] out_d;   // Agreed value, next
    logic [WIDTH-1:0] out_q;   // Agreed value

    // Per bit: follow when both late stages agree, else hold
    always_comb begin
        out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end

    // Stage registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q  <= RESET_VAL;
            s2_q  <= RESET_VAL;
            s3_q  <= RESET_VAL;
            out_q <= RESET_VAL;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;

endmodule

// ===== rtl/eeprom_spi_front.sv
// Serial EEPROM slave front end: framing, opcodes, latch, status register
// What this block does
// - Slave only; serial clock always an input.
// - All bytes move most significant bit first.
// - First byte after select falls is opcode.
// - 8-bit opcode register; frames start on select fall.
// - Bad opcode: ignore input, output off till reselect.
// - Deselected: ignore input, output high impedance.
// - Paused: keep state, output off from the next falling sck, input ignored.
// - Protect pin high allows normal writes.
// - Pin low and protect bit set: refuse status writes.
// - Pin falling during frame aborts pending status write.
// - Started status write ignores later pin fall.
// - Protect bit clear: pin fully ignored.
// - Decode set latch, clear latch, read status.
// - Decode write status; read array, write array ignored.
// - Write latch cleared at power-up.
// - Clear latch works regardless of protect pin.
// - Status byte: protect, level, latch, busy layout.
// - Level bits change only by write status.
// - Busy reads one during write cycle.
// - While busy, only read status is honoured.
// - Level bits pick none, quarter, half, all.
// - Write latch clears when write cycle completes.
`timescale 1ns/100ps
module eeprom_spi_front
    import eeprom_spi_pkg::*;
#(
    parameter int WC_CYCLES = WRITE_CYCLES  // Write cycle length in mclk
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       hold_n,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe,
    output logic [1:0]      protect_level,
    output logic            busy
);

    // Link side, clocked by the master's sck
    logic           frame_rst;      // Select high or reset ends the frame
    phase_e         phase_d;        // Frame phase, next
    phase_e         phase_q;        // Frame phase
    logic [2:0]     cnt_d;          // Bit index in byte, next
    logic [2:0]     cnt_q;          // Bit index in byte
    logic [7:0]     rx_d;           // Receive shifter, next
    logic [7:0]     rx_q;           // Receive shifter
    logic [7:0]     rx_next;        // Shifter with current bit
    logic [7:0]     tx_d;           // Status byte being sent, next
    logic [7:0]     tx_q;           // Status byte being sent
    logic [7:0]     status_view;    // Status byte as seen on the link
    logic           link_busy;      // Write cycle in progress, link view
    logic           set_tog_d;      // Set-latch event toggle, next
    logic           set_tog_q;      // Set-latch event toggle
    logic           clr_tog_d;      // Clear-latch event toggle, next
    logic           clr_tog_q;      // Clear-latch event toggle
    logic           wsr_tog_d;      // Status-data event toggle, next
    logic           wsr_tog_q;      // Status-data event toggle
    logic [7:0]     wsr_data_d;     // Captured status data, next
    logic [7:0]     wsr_data_q;     // Captured status data
    logic           so_d;           // Serial output bit, next
    logic           so_oe_d;        // Serial output enable, next
    logic [7:0]     status_pub_q;   // Status published by mclk side

    // A deselect clears the frame at once; sck may never tick again
    assign frame_rst = rst | cs_n;

    // Published status word reaches the link through the agree sync;
    // it only changes on writes, well apart from any read frame
    sync_agree #(
        .WIDTH     (8),
        .RESET_VAL (STATUS_RESET_VIEW)
    ) u_status_sync (
        .clk  (sck),
        .rst  (rst),
        .din  (status_pub_q),
        .dout (status_view)
    );

    assign link_busy = status_view[ST_BUSY_BIT];

    // Frame and event next state, evaluated at each rising sck
    always_comb begin
        rx_next    = {rx_q[6:0], si};
        phase_d    = phase_q;
        cnt_d      = cnt_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        set_tog_d  = set_tog_q;
        clr_tog_d  = clr_tog_q;
        wsr_tog_d  = wsr_tog_q;
        wsr_data_d = wsr_data_q;
        // Paused or ignoring: every register holds
        if (hold_n && phase_q != PH_IGNORE) begin
            cnt_d = cnt_q + 3'h1;
            rx_d  = rx_next;
            if (cnt_q == LAST_BIT) begin
                case (phase_q)
                    PH_OPCODE: begin
                        // First byte of a frame is the opcode
                        phase_d = PH_IGNORE;  // Array, bad codes
                        if ((rx_next & OPCODE_MASK)
                                == READ_STATUS_CMD) begin
                            phase_d = PH_STATUS_OUT;
                            tx_d    = status_view;
                        end else if (link_busy) begin
                            phase_d = PH_IGNORE;  // Busy drops all
                        end else if ((rx_next & OPCODE_MASK)
                                == SET_WRITE_LATCH_CMD) begin
                            set_tog_d = ~set_tog_q;
                        end else if ((rx_next & OPCODE_MASK)
                                == CLEAR_WRITE_LATCH_CMD) begin
                            clr_tog_d = ~clr_tog_q;
                        end else if ((rx_next & OPCODE_MASK)
                                == WRITE_STATUS_CMD) begin
                            phase_d = PH_STATUS_DATA;
                        end
                    end
                    PH_STATUS_OUT: begin
                        // Keep repeating a fresh status byte
                        tx_d = status_view;
                    end
                    PH_STATUS_DATA: begin
                        // Hand the byte over; commit waits for deselect
                        wsr_data_d = rx_next;
                        wsr_tog_d  = ~wsr_tog_q;
                        phase_d    = PH_IGNORE;
                    end
                    default: begin
                        phase_d = PH_IGNORE;
                    end
                endcase
            end
        end
    end

    // Frame registers, cleared whenever select is high
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            phase_q <= PH_OPCODE;
            cnt_q   <= '0;
            rx_q    <= '0;
            tx_q    <= '0;
        end else begin
            phase_q <= phase_d;
            cnt_q   <= cnt_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
        end
    end

    // Event registers survive deselect so mclk side can see them
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            set_tog_q  <= 1'b0;
            clr_tog_q  <= 1'b0;
            wsr_tog_q  <= 1'b0;
            wsr_data_q <= '0;
        end else begin
            set_tog_q  <= set_tog_d;
            clr_tog_q  <= clr_tog_d;
            wsr_tog_q  <= wsr_tog_d;
            wsr_data_q <= wsr_data_d;
        end
    end

    // Output bit and enable for the falling edge
    always_comb begin
        so_d    = tx_q[~cnt_q];
        // Drive only mid status read and not paused
        so_oe_d = hold_n && (phase_q == PH_STATUS_OUT);
    end

    // Output moves after falling sck; deselect floats it at once.
    // A pause takes the pin off at the next falling edge only.
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so    <= so_d;
            so_oe <= so_oe_d;
        end
    end

    // Core side, clocked by mclk
    logic [2:0]     tog_sync;       // Synced set, clear, data toggles
    logic [2:0]     tog_seen_d;     // Last toggles acted on, next
    logic [2:0]     tog_seen_q;     // Last toggles acted on
    logic [1:0]     pin_sync;       // Synced {cs_n, wp_n}
    logic           wp_prev_d;      // Protect pin last cycle, next
    logic           wp_prev_q;      // Protect pin last cycle
    logic           sel_low;        // Frame in progress
    logic           wp_low;         // Protect pin low
    logic           hw_locked;      // Hardware protection in force
    wstate_e        ws_d;           // Status write state, next
    wstate_e        ws_q;           // Status write state
    logic           latch_d;        // Write-enable latch, next
    logic           latch_q;        // Write-enable latch
    logic [1:0]     level_d;        // Block-protect level, next
    logic [1:0]     level_q;        // Block-protect level
    logic           prot_d;         // Protect-enable bit, next
    logic           prot_q;         // Protect-enable bit
    logic [7:0]     pend_d;         // Status byte awaiting commit, next
    logic [7:0]     pend_q;         // Status byte awaiting commit
    logic [WC_CNT_W-1:0] wc_d;      // Write cycle countdown, next
    logic [WC_CNT_W-1:0] wc_q;      // Write cycle countdown
    logic [7:0]     status_pub_d;   // Status to publish, next
    logic           busy_d;         // Busy output, next

    // Toggles from the link: level crossing, edge found downstream
    sync_agree #(
        .WIDTH     (3),
        .RESET_VAL (3'h0)
    ) u_tog_sync (
        .clk  (mclk),
        .rst  (rst),
        .din  ({wsr_tog_q, clr_tog_q, set_tog_q}),
        .dout (tog_sync)
    );

    // Select and protect pins; both idle high
    sync_agree #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_pin_sync (
        .clk  (mclk),
        .rst  (rst),
        .din  ({cs_n, wp_n}),
        .dout (pin_sync)
    );

    assign sel_low   = ~pin_sync[1];
    assign wp_low    = ~pin_sync[0];
    // Pin counts only when protect bit set
    assign hw_locked = prot_q & wp_low;

    // Latch, status fields and write cycle sequencing
    always_comb begin
        tog_seen_d   = tog_sync;
        wp_prev_d    = pin_sync[0];
        ws_d         = ws_q;
        latch_d      = latch_q;
        level_d      = level_q;
        prot_d       = prot_q;
        pend_d       = pend_q;
        wc_d         = wc_q;
        case (ws_q)
            WS_IDLE, WS_ARMED: begin
                // Latch commands, pin level not consulted
                if (tog_sync[1] != tog_seen_q[1]) begin
                    latch_d = 1'b0;
                end
                // Set applied last so it wins a same-cycle clash
                if (tog_sync[0] != tog_seen_q[0]) begin
                    latch_d = 1'b1;
                end
                if (tog_sync[2] != tog_seen_q[2]) begin
                    pend_d = wsr_data_q;  // Stable: its toggle moved
                    ws_d   = WS_ARMED;
                end else if (ws_q == WS_ARMED) begin
                    if (sel_low && wp_low && wp_prev_q && prot_q) begin
                        ws_d = WS_IDLE;
                    end else if (!sel_low) begin
                        // Needs latch and no hardware lock
                        if (latch_q && !hw_locked) begin
                            ws_d = WS_BUSY;
                            wc_d = WC_CNT_W'(WC_CYCLES - 1);
                        end else begin
                            ws_d = WS_IDLE;
                        end
                    end
                end
            end
            WS_BUSY: begin
                // Pin is not looked at once started; commands drop
                if (wc_q == '0) begin
                    ws_d    = WS_IDLE;
                    level_d = pend_q[ST_LEVEL_HI_BIT:ST_LEVEL_LO_BIT];
                    prot_d  = pend_q[ST_PROTECT_BIT];
                    latch_d = 1'b0;
                end else begin
                    wc_d = wc_q - 1'b1;
                end
            end
            default: begin
                ws_d = WS_IDLE;
            end
        endcase
        // Busy shows all ones, else the live fields
        busy_d = (ws_d == WS_BUSY);
        if (busy_d) begin
            status_pub_d = STATUS_BUSY_VIEW;
        end else begin
            status_pub_d                  = '0;
            status_pub_d[ST_PROTECT_BIT]  = prot_d;
            status_pub_d[ST_LEVEL_HI_BIT] = level_d[1];
            status_pub_d[ST_LEVEL_LO_BIT] = level_d[0];
            status_pub_d[ST_LATCH_BIT]    = latch_d;
        end
    end

    // Core registers; latch starts cleared at power-up
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tog_seen_q   <= 3'h0;
            wp_prev_q    <= 1'b1;
            ws_q         <= WS_IDLE;
            latch_q      <= 1'b0;
            level_q      <= LEVEL_RESET;
            prot_q       <= PROTECT_RESET;
            pend_q       <= '0;
            wc_q         <= '0;
            status_pub_q <= STATUS_RESET_VIEW;
            busy         <= 1'b0;
            protect_level <= LEVEL_RESET;
        end else begin
            tog_seen_q   <= tog_seen_d;
            wp_prev_q    <= wp_prev_d;
            ws_q         <= ws_d;
            latch_q      <= latch_d;
            level_q      <= level_d;
            prot_q       <= prot_d;
            pend_q       <= pend_d;
            wc_q         <= wc_d;
            status_pub_q <= status_pub_d;
            busy         <= busy_d;
            protect_level <= level_d;
        end
    end

endmodule

// ===== dv/eeprom_spi_front_chk.sv
// Port-level concurrent checks for the serial front end
`timescale 1ns/100ps
module eeprom_spi_front_chk
    import eeprom_spi_pkg::*;
#(
    parameter int WC_CYCLES = WRITE_CYCLES  // Write cycle length in mclk
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic       si,
    input wire logic       hold_n,
    input wire logic       wp_n,
    input wire logic       so,
    input wire logic       so_oe,
    input wire logic [1:0] protect_level,
    input wire logic       busy
);
    logic [3:0]  cnt_q, cnt_d;  // Bits taken this frame, saturating
    logic [7:0]  op_q, op_d;    // Opcode seen this frame
    logic [31:0] bc_q, bc_d;    // Cycles spent busy
    logic        is_rd;         // Frame opcode reads status

    // Frame tracking; paused bits are not counted
    always_comb begin
        cnt_d = cnt_q;
        op_d  = op_q;
        if (hold_n && cnt_q < 4'h9) begin
            cnt_d = cnt_q + 4'h1;
        end
        if (hold_n && cnt_q < 4'h8) begin
            op_d = {op_q[6:0], si};
        end
    end

    // Select high restarts the frame at once
    always_ff @(posedge sck or posedge rst or posedge cs_n) begin
        if (rst || cs_n) begin
            cnt_q <= 4'h0;
            op_q  <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
            op_q  <= op_d;
        end
    end

    assign is_rd = (op_q & OPCODE_MASK) == READ_STATUS_CMD;

    // Busy length counter
    always_comb bc_d = busy ? bc_q + 32'h1 : 32'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bc_q <= 32'h0;
        end else begin
            bc_q <= bc_d;
        end
    end

    sequence s_done;
        $fell(busy);
    endsequence

    sequence s_start;
        $rose(busy);
    endsequence

    a_desel_quiet: assert property (
        @(posedge mclk) disable iff (rst) cs_n |-> !so_oe)
        else $error("output driven while deselected");
    a_no_early_oe: assert property (
        @(posedge sck) disable iff (rst || cs_n) cnt_q < 4'h8 |-> !so_oe)
        else $error("output driven during opcode");
    a_bad_op_quiet: assert property (
        @(posedge sck) disable iff (rst || cs_n)
        cnt_q >= 4'h8 && !is_rd |-> !so_oe)
        else $error("output driven after non-read opcode");
    a_read_drives: assert property (
        @(posedge sck) disable iff (rst || cs_n)
        cnt_q >= 4'h8 && is_rd && hold_n && $past(hold_n) |-> so_oe)
        else $error("status read not driven");
    a_pause_quiet: assert property (
        @(posedge sck) disable iff (rst || cs_n)
        !hold_n && !$past(hold_n) |-> !so_oe)
        else $error("output driven during pause");
    a_busy_length: assert property (
        @(posedge mclk) disable iff (rst)
        s_done |-> bc_q >= WC_CYCLES - 1 && bc_q <= WC_CYCLES + 1)
        else $error("write cycle length wrong");
    a_busy_bound: assert property (
        @(posedge mclk) disable iff (rst) bc_q <= WC_CYCLES + 1)
        else $error("busy stuck high");
    a_level_on_done: assert property (
        @(posedge mclk) disable iff (rst) $changed(protect_level)
        |-> !busy && ($past(busy) || $past(busy, 2)))
        else $error("level changed outside a write cycle");
    a_start_desel: assert property (
        @(posedge mclk) disable iff (rst) s_start |-> cs_n && $past(cs_n, 3))
        else $error("write cycle began inside a frame");
    a_reset_quiet: assert property (
        @(posedge mclk) rst |-> !busy && protect_level == 2'h0 && !so_oe)
        else $error("outputs active in reset");
endmodule

bind eeprom_spi_front eeprom_spi_front_chk #(.WC_CYCLES(WC_CYCLES)) u_chk (
    .mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .protect_level(protect_level), .busy(busy));

// ===== dv/spi_master_model.sv
// Host serial master model: makes sck, frames, pauses, reads back
`timescale 1ns/100ps
module spi_master_model (
    output logic       sck,
    output logic       cs_n,
    output logic       si,
    output logic       hold_n,
    input  wire logic  so,
    input  wire logic  so_oe,
    output logic [7:0] rx_byte,
    output logic       rx_stb
);
    wire so_line;  // Pin level; floats when the slave lets go
    assign so_line = so_oe ? so : 1'bz;

    // Idle bus: deselected, clock still
    initial begin
        sck     = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
        hold_n  = 1'b1;
        rx_byte = 8'h00;
        rx_stb  = 1'b0;
    end

    // One frame of nb bytes; pause at bit pz; late delays deselect
    task automatic xfer(input logic [15:0] w, input int nb, input bit rd,
                        input int pz, input int late);
        int i;
        int k;
        bit md;
        md = 1'($urandom);             // Mode 0 or 3, chosen per frame
        sck = md;
        #22 cs_n = 1'b0;
        #15;
        for (i = 0; i < 8 * nb; i++) begin
            sck = 1'b0;
            si = w[15 - i];            // Most significant bit first
            if (i == pz) begin
                hold_n = 1'b0;         // Pause only with clock low
                for (k = 0; k < 4; k++) begin
                    #15 sck = 1'b1;
                    #15 sck = 1'b0;
                    si = 1'($urandom); // Junk the slave must ignore
                end
                hold_n = 1'b1;         // Resume with clock low
                si = w[15 - i];
            end
            #15 sck = 1'b1;            // Only the master clocks
            if (i >= 8) rx_byte[15 - i] = so_line;
            #15;
        end
        sck = md;
        #(15 + late) cs_n = 1'b1;
        si = ~si;                      // Released line shows no stale bit
        if (rd) begin
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
    endtask
endmodule

// ===== dv/tb_eeprom_spi_front.sv
// Self-checking bench for the serial front end
`timescale 1ns/100ps
module tb_eeprom_spi_front
    import eeprom_spi_pkg::*;
;
    localparam int WC = 200;       // Shortened write cycle
    logic       mclk, rst, wp_n;
    logic       sck, cs_n, si, hold_n, so, so_oe, busy, rx_stb;
    logic [1:0] protect_level;
    logic [7:0] rx_byte;
    int         errors, total_checks, seed, i;
    logic [7:0] expq[$];           // Expected status bytes, oldest first

    eeprom_spi_front #(.WC_CYCLES(WC)) dut (.mclk(mclk), .rst(rst),
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .protect_level(protect_level),
        .busy(busy));
    spi_master_model master (.sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .so(so), .so_oe(so_oe), .rx_byte(rx_byte),
        .rx_stb(rx_stb));

    always #5 mclk = ~mclk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic results();
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Deselect time between frames
    task automatic gap();
        repeat (8) @(posedge mclk);
    endtask

    // Bit 3 of the opcode is random since it is don't-care
    function automatic logic [7:0] op(input logic [7:0] base);
        return base | {4'h0, 1'($urandom), 3'h0};
    endfunction

    task automatic cmd(input logic [7:0] o, input logic [7:0] d, input int n);
        master.xfer({op(o), d}, n, 1'b0, -1, 0);
        gap();
    endtask

    // Status read with a pause inside the opcode
    task automatic read_status_cmd(input logic [7:0] exp);
        expq.push_back(exp);
        master.xfer({op(READ_STATUS_CMD), 8'h00}, 2, 1'b1,
                    $urandom_range(1, 6), 0);
        gap();
    endtask

    task automatic write_status_cmd(input logic [7:0] d);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1); // latch first
        cmd(WRITE_STATUS_CMD, d, 2);
    endtask

    // Bounded wait for a busy level
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 3 * WC && busy !== lvl; n++) begin
            @(posedge mclk);
        end
        chk({7'h0, busy}, {7'h0, lvl});
    endtask

    // Compare each returned status byte with the oldest note
    always @(posedge rx_stb) begin
        if (expq.size() == 0) begin
            errors++;
            $display("CHECK FAILED t=%0t status byte not expected", $time);
        end else begin
            chk(rx_byte, expq.pop_front());
        end
    end

    // Watchdog well beyond the expected run
    initial begin
        #100_000;
        errors++;
        results();
    end

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        wp_n = 1'b1;
        errors = 0;
        total_checks = 0;
        seed = $urandom(97228);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        gap();
        read_status_cmd(8'h00);
        chk({6'h0, protect_level}, 8'h00);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        read_status_cmd(8'h02);
        wp_n <= 1'b0;
        cmd(CLEAR_WRITE_LATCH_CMD, 8'h00, 1);
        read_status_cmd(8'h00);
        wp_n <= 1'b1;
        // Array opcodes and unknown opcodes are all ignored
        for (i = 0; i < 6; i++) begin
            cmd(i < 2 ? READ_ARRAY_CMD - 8'(i) : 8'h10 | 8'($urandom),
                8'($urandom), 2);
        end
        cmd(WRITE_STATUS_CMD, 8'h8C, 2);
        read_status_cmd(8'h00);
        write_status_cmd(8'h8C);
        wait_busy(1'b1);
        read_status_cmd(8'hFF);
        cmd(WRITE_STATUS_CMD, 8'h00, 2);
        wait_busy(1'b0);
        read_status_cmd(8'h8C);
        chk({6'h0, protect_level}, 8'h03);
        wp_n <= 1'b0;
        write_status_cmd(8'h00);
        chk({7'h0, busy}, 8'h00);
        cmd(CLEAR_WRITE_LATCH_CMD, 8'h00, 1);
        read_status_cmd(8'h8C);
        wp_n <= 1'b1;
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        // Pin falls while the select is still low
        fork
            master.xfer({op(WRITE_STATUS_CMD), 8'h00}, 2, 1'b0, -1, 400);
            begin
                #600;
                @(posedge mclk) wp_n <= 1'b0;
            end
        join
        gap();
        chk({7'h0, busy}, 8'h00);
        cmd(CLEAR_WRITE_LATCH_CMD, 8'h00, 1);
        read_status_cmd(8'h8C);
        wp_n <= 1'b1;
        write_status_cmd(8'h00);
        wait_busy(1'b1);
        wp_n <= 1'b0;
        wait_busy(1'b0);
        read_status_cmd(8'h00);
        chk({6'h0, protect_level}, 8'h00);
        // Protect bit clear: pin low has no say
        for (i = 1; i < 3; i++) begin
            write_status_cmd({4'h0, 2'(i), 2'h0});
            wait_busy(1'b1);
            wait_busy(1'b0);
            read_status_cmd({4'h0, 2'(i), 2'h0});
            chk({6'h0, protect_level}, 8'(i));
        end
        results();
    end
endmodule
